// *** logic/rtc_top.sv ***
/*
 Real-time clock with backup storage behind an APB slave.
 Assumes pclk is always running, including during Stop and Standby, and
 that presetn is the backup-domain reset only.
*/
// Decided for this implementation: the register addresses and the APB register port.
// Function
// - Ten 16-bit backup words, retained
// - Counters run; alarm and periodic interrupts
// - Source: 32.768k, 40k, or fast/128
// - Drive 512 Hz calibration output from 32.768k; other sources give their tick/64
// - Loadable 32-bit counter, alarm on compare
// - 20-bit prescaler, reset gives one second
// - Alarm drives external event line wake
// - Alarm causes exit from Standby
// - Keeps running in Stop and Standby
// - Registers retained through Standby
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lse_tick,
   input  wire logic        lsi_tick,
   input  wire logic        fast_external_osc_clock_tick,
   input  wire logic        standby,
   output logic             irq,
   output logic             cal_out,
   output logic             alarm_event_line,
   output logic             standby_wake
);
   import rtc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   src_sel_t                  sel_q;
   logic                      cal_en_q;
   logic [`RTC_EV_W-1:0]      status_q;
   logic [`RTC_EV_W-1:0]      mask_q;
   logic [`RTC_CNT_W-1:0]     alarm_q;
   logic [`RTC_BKP_W-1:0]     bkp_q [`RTC_BKP_WORDS];
   logic [`RTC_CAL_DIV_W-1:0] cal_div_q;
   rtc_ctl_t                  ctl;
   rtc_events_t               ev;
   logic                      tick;
   logic [`RTC_PRE_W-1:0]     div_cnt;
   logic [`RTC_CNT_W-1:0]     cnt;
   logic                      wr_en;
   logic                      rd_en;
   logic [`RTC_EV_W-1:0]      ev_vec;

   // Address decode shared by read and write paths
   function automatic logic is_bkp(input logic [11:0] a);
      return (a >= `RTC_OFF_BKP0) && (a < `RTC_OFF_BKP0 + 4 * `RTC_BKP_WORDS) && (a[1:0] == 2'b00);
   endfunction : is_bkp

   function automatic logic [`RTC_BKP_IDX_W-1:0] bkp_idx(input logic [11:0] a);
      logic [11:0] d;
      d = a - `RTC_OFF_BKP0;
      return d[`RTC_BKP_IDX_W+1:2];
   endfunction : bkp_idx

   function automatic logic is_mapped(input logic [11:0] a);
      unique case (a)
         `RTC_OFF_CTRL, `RTC_OFF_STATUS, `RTC_OFF_MASK, `RTC_OFF_PRESC,
         `RTC_OFF_DIVCNT, `RTC_OFF_COUNT, `RTC_OFF_ALARM: return 1'b1;
         default: return is_bkp(a);
      endcase
   endfunction : is_mapped

   // One wait state; a write lands only at the edge that sees pready high,
   // so a master that aborts before the answer changes nothing
   assign wr_en  = psel && penable && pwrite && pready;
   assign rd_en  = psel && penable && !pwrite && !pready;
   assign ev_vec = {ev.period, ev.alarm};

   // ---------------------------------------------------------------
   // Counter chain
   // ---------------------------------------------------------------
   rtc_clk_select u_sel (
      .pclk                         (pclk),
      .presetn                      (presetn),
      .sel                          (sel_q),
      .lse_tick                     (lse_tick),
      .lsi_tick                     (lsi_tick),
      .fast_external_osc_clock_tick (fast_external_osc_clock_tick),
      .tick                         (tick)
   );

   // Load strobes pulse on the write cycle only
   always_comb begin
      ctl.presc_wr = wr_en && (paddr == `RTC_OFF_PRESC);
      ctl.presc    = pwdata[`RTC_PRE_W-1:0];
      ctl.cnt_wr   = wr_en && (paddr == `RTC_OFF_COUNT);
      ctl.cnt      = pwdata;
      ctl.alarm    = alarm_q;
   end

   rtc_counter u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .ctl     (ctl),
      .div_q   (div_cnt),
      .cnt_q   (cnt),
      .ev      (ev)
   );

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q    <= SRC_LSE;
         cal_en_q <= 1'b0;
         mask_q   <= '0;
         alarm_q  <= `RTC_ALARM_RST;
      end else if (wr_en) begin
         unique case (paddr)
            `RTC_OFF_CTRL: begin
               // Illegal source code falls back to the crystal
               if (pwdata[`RTC_CTRL_SEL_HI:`RTC_CTRL_SEL_LO] == 2'b11) begin
                  sel_q <= SRC_LSE;
               end else begin
                  sel_q <= src_sel_t'(pwdata[`RTC_CTRL_SEL_HI:`RTC_CTRL_SEL_LO]);
               end
               cal_en_q <= pwdata[`RTC_CTRL_CAL_EN];
            end
            `RTC_OFF_MASK:  mask_q  <= pwdata[`RTC_EV_W-1:0];
            `RTC_OFF_ALARM: alarm_q <= pwdata;
            default: ;
         endcase
      end
   end

   // Sticky status; a new event wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~((wr_en && paddr == `RTC_OFF_STATUS) ? pwdata[`RTC_EV_W-1:0] : '0))
                     | ev_vec;
      end
   end

   // Backup words live in the retained domain; only presetn clears them
   genvar gi;
   generate
      for (gi = 0; gi < `RTC_BKP_WORDS; gi++) begin : g_bkp
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               bkp_q[gi] <= '0;
            end else if (wr_en && is_bkp(paddr) && bkp_idx(paddr) == gi) begin
               bkp_q[gi] <= pwdata[`RTC_BKP_W-1:0];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Interrupt level follows any enabled sticky flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // Wake paths: the alarm pulse reaches the event line unmasked so that
   // Stop exit does not depend on software state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_event_line <= 1'b0;
         standby_wake     <= 1'b0;
      end else begin
         alarm_event_line <= ev.alarm;
         standby_wake     <= ev.alarm && standby;
      end
   end

   // 512 Hz calibration: toggle every 32 ticks of 32.768 kHz
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_div_q <= '0;
         cal_out   <= 1'b0;
      end else if (!cal_en_q) begin
         cal_div_q <= '0;
         cal_out   <= 1'b0;
      end else if (tick) begin
         cal_div_q <= cal_div_q + 1'b1;
         if (cal_div_q[`RTC_CAL_DIV_W-2:0] == '1) begin
            cal_out <= !cal_out;
         end
      end
   end

   // APB answer: one wait state, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !is_mapped(paddr);
         prdata  <= '0;
         if (rd_en) begin
            unique case (paddr)
               `RTC_OFF_CTRL:   prdata <= {29'h0, cal_en_q, sel_q};
               `RTC_OFF_STATUS: prdata <= {30'h0, status_q};
               `RTC_OFF_MASK:   prdata <= {30'h0, mask_q};
               `RTC_OFF_PRESC:  prdata <= {12'h0, u_cnt.reload_q};
               `RTC_OFF_DIVCNT: prdata <= {12'h0, div_cnt};
               `RTC_OFF_COUNT:  prdata <= cnt;
               `RTC_OFF_ALARM:  prdata <= alarm_q;
               default: begin
                  if (is_bkp(paddr)) begin
                     prdata <= {16'h0, bkp_q[bkp_idx(paddr)]};
                  end
               end
            endcase
         end
      end
   end

endmodule : rtc_top
`default_nettype wire

// *** logic/rtc_defs.svh ***
/*
 Register offsets, field positions, reset values and timing counts of the
 real-time clock with backup storage.
 Assumes inclusion by bare name from the package and design modules.
*/
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RTC_OFF_CTRL     12'h000
`define RTC_OFF_STATUS   12'h004
`define RTC_OFF_MASK     12'h008
`define RTC_OFF_PRESC    12'h00C
`define RTC_OFF_DIVCNT   12'h010
`define RTC_OFF_COUNT    12'h014
`define RTC_OFF_ALARM    12'h018
`define RTC_OFF_BKP0     12'h040
`define RTC_BKP_WORDS    10
`define RTC_BKP_IDX_W    4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTC_CTRL_SEL_LO  0
`define RTC_CTRL_SEL_HI  1
`define RTC_CTRL_CAL_EN  2
`define RTC_ST_ALARM     0
`define RTC_ST_PERIOD    1
`define RTC_EV_W         2

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define RTC_PRE_W        20
`define RTC_CNT_W        32
`define RTC_BKP_W        16
`define RTC_PRESC_RST    20'h0_7FFF
`define RTC_ALARM_RST    32'hFFFF_FFFF
`define RTC_FAST_DIV     128
`define RTC_FAST_DIV_W   7
`define RTC_CAL_DIV      64
`define RTC_CAL_DIV_W    6

`endif

// *** logic/rtc_pkg.sv ***
/*
 Types shared by the real-time clock modules.
 Assumes rtc_defs.svh on the include path.
*/
`include "rtc_defs.svh"

package rtc_pkg;

   // Selected low-frequency source
   typedef enum logic [1:0] {
      SRC_LSE,
      SRC_LSI,
      SRC_FAST_DIV
   } src_sel_t;

   // Event flags raised by the counter chain
   typedef struct packed {
      logic period;
      logic alarm;
   } rtc_events_t;

   // Counter chain control from the register file
   typedef struct packed {
      logic                   presc_wr;
      logic [`RTC_PRE_W-1:0]  presc;
      logic                   cnt_wr;
      logic [`RTC_CNT_W-1:0]  cnt;
      logic [`RTC_CNT_W-1:0]  alarm;
   } rtc_ctl_t;

endpackage : rtc_pkg

// *** logic/rtc_clk_select.sv ***
/*
 Source selector: picks one of three low-frequency ticks and produces a
 one-cycle tick enable on pclk.
 Assumes source tick inputs are synchronous one-cycle pulses on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_clk_select (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire rtc_pkg::src_sel_t sel,
   input  wire logic             lse_tick,
   input  wire logic             lsi_tick,
   input  wire logic             fast_external_osc_clock_tick,
   output logic                  tick
);
   import rtc_pkg::*;

   logic [`RTC_FAST_DIV_W-1:0] hdiv_q;

   // ---------------------------------------------------------------
   // Fast source divided by 128
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdiv_q <= '0;
      end else if (fast_external_osc_clock_tick) begin
         hdiv_q <= hdiv_q + 1'b1;
      end
   end

   // Mux the chosen source; the divider wraps at 128 ticks
   always_comb begin
      unique case (sel)
         SRC_LSE:     tick = lse_tick;
         SRC_LSI:     tick = lsi_tick;
         SRC_FAST_DIV: tick = fast_external_osc_clock_tick && (&hdiv_q);
         default:     tick = 1'b0;
      endcase
   end

endmodule : rtc_clk_select
`default_nettype wire

// *** logic/rtc_counter.sv ***
/*
 Prescaler and 32-bit counter chain with alarm compare.
 Assumes a one-cycle source tick on pclk and load strobes from registers.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_counter (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  tick,
   input  wire rtc_pkg::rtc_ctl_t     ctl,
   output logic [`RTC_PRE_W-1:0]      div_q,
   output logic [`RTC_CNT_W-1:0]      cnt_q,
   output rtc_pkg::rtc_events_t       ev
);
   import rtc_pkg::*;

   logic [`RTC_PRE_W-1:0] reload_q;
   logic                  base;

   assign base = tick && (div_q == '0);

   // ---------------------------------------------------------------
   // Prescaler: reload at zero gives one base pulse per reload+1 ticks
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_q <= `RTC_PRESC_RST;
         div_q    <= `RTC_PRESC_RST;
      end else if (ctl.presc_wr) begin
         reload_q <= ctl.presc;
         div_q    <= ctl.presc;
      end else if (tick) begin
         div_q <= base ? reload_q : div_q - 1'b1;
      end
   end

   // Counter runs free; software load has priority over a step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (ctl.cnt_wr) begin
         cnt_q <= ctl.cnt;
      end else if (base) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Events are one-cycle pulses; the alarm fires on reaching compare
   always_comb begin
      ev.period = base;
      ev.alarm  = base && !ctl.cnt_wr && (cnt_q + 1'b1 == ctl.alarm);
   end

endmodule : rtc_counter
`default_nettype wire

// *** verification/rtc_top_monitor.sv ***
/*
 Port checker for the real-time clock block.
 Assumes binding into rtc_top; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module rtc_top_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        standby,
   input wire logic        irq,
   input wire logic        alarm_event_line,
   input wire logic        standby_wake
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------
   // Bus answer timing
   // ------
   wait_state_a: assert property (psel && penable && !pready |=> pready)
      else $error("no ready one cycle after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error outside ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero when idle");
   mapped_ok_a: assert property (pready && paddr[1:0] == 2'b00
      && (paddr <= 12'h018 || (paddr >= 12'h040 && paddr <= 12'h064)) |-> !pslverr)
      else $error("error on mapped word");

   // ------
   // Alarm wake paths
   // ------
   alarm_pulse_a: assert property (alarm_event_line |=> !alarm_event_line)
      else $error("alarm line held");
   wake_alarm_a: assert property (standby_wake |-> alarm_event_line && $past(standby))
      else $error("wake without alarm in standby");

   // Main scenarios reached
   cover property (alarm_event_line);
   cover property (standby_wake);
   cover property ($rose(irq));
endmodule : rtc_top_monitor

bind rtc_top rtc_top_monitor u_rtc_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .standby(standby), .irq(irq),
   .alarm_event_line(alarm_event_line), .standby_wake(standby_wake));

`default_nettype wire

// *** verification/tb_rtc_top.sv ***
/*
 Self-checking bench for the real-time clock block.
 Assumes the logic/ sources are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_rtc_top;
   logic        pclk, presetn, psel, penable, pwrite, standby;
   logic        pready, pslverr, irq, cal_out, al_ev, wake, saw_al, saw_wk, ev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, c;
   logic [2:0]  tk;
   logic [15:0] bk [10];
   int          err_count, tests_run, p;

   rtc_top u_rtc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lse_tick(tk[0]), .lsi_tick(tk[1]), .fast_external_osc_clock_tick(tk[2]),
      .standby(standby), .irq(irq), .cal_out(cal_out), .alarm_event_line(al_ev), .standby_wake(wake));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Pulses last one cycle, so latch them for later checks
   always @(posedge pclk) begin
      if (al_ev === 1'b1) saw_al <= 1'b1;
      if (wake === 1'b1) saw_wk <= 1'b1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One bus transfer; idle edge at the end avoids re-raising psel at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never gets its answer
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rv, exp);
   endtask : rdc

   task automatic tick(input int s, input int n);
      repeat (n) begin
         tk[s] <= 1'b1;
         @(posedge pclk);
         tk[s] <= 1'b0;
         @(posedge pclk);
      end
   endtask : tick

   // Fast source is divided down, the slow ones count directly
   function automatic logic [31:0] exp_delta(input int s);
      return (s == 2) ? 32'h0000_0001 : 32'h0000_0003;
   endfunction : exp_delta

   task automatic test_done;
      $display("tests run %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   initial begin
      #(100 * 30000);
      err_count++;
      test_done();
   end

   initial begin
      {psel, penable, pwrite, standby, saw_al, saw_wk, presetn} = '0;
      paddr = '0;
      pwdata = '0;
      tk = '0;
      err_count = 0;
      tests_run = 0;
      void'($urandom(61395));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // ------
      // Reset values
      // ------
      rdc(12'h000, 32'h0000_0000);
      rdc(12'h00C, 32'h0000_7FFF);
      rdc(12'h018, 32'hFFFF_FFFF);
      rdc(12'h014, 32'h0000_0000);
      rdc(12'h004, 32'h0000_0000);
      $display("reset test done");
      // ------
      // Calibration output
      // ------
      apb(1'b1, 12'h000, 32'h0000_0004);
      tick(0, 32);
      chk(cal_out, 1);
      tick(0, 32);
      chk(cal_out, 0);
      $display("calibration test done");
      // ------
      // Source select and prescaler
      // ------
      apb(1'b1, 12'h00C, 32'h0000_0000);
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, 12'h000, 32'(s));
         apb(1'b0, 12'h014, 32'h0000_0000);
         c = rv;
         for (int k = 0; k < 3; k++) tick(k, (k == s && s == 2) ? 128 : 3);
         rdc(12'h014, c + exp_delta(s));
      end
      p = $urandom_range(4, 1);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b1, 12'h00C, 32'(p));
      apb(1'b0, 12'h014, 32'h0000_0000);
      c = rv;
      tick(0, 3 * (p + 1));
      rdc(12'h014, c + 32'h0000_0003);
      rdc(12'h010, 32'(p));
      $display("source test done");
      // ------
      // Backup words and unmapped access
      // ------
      for (int i = 0; i < 10; i++) begin
         bk[i] = 16'($urandom);
         apb(1'b1, 12'h040 + 12'(4 * i), {16'hFFFF, bk[i]});
      end
      apb(1'b0, 12'h068, 32'h0000_0000);
      chk(ev, 1);
      chk(rv, 32'h0000_0000);
      $display("backup test done");
      // ------
      // Alarm in standby, sticky flags, masking
      // ------
      apb(1'b1, 12'h00C, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0001);
      standby <= 1'b1;
      saw_al <= 1'b0;
      saw_wk <= 1'b0;
      c = $urandom;
      apb(1'b1, 12'h014, c);
      apb(1'b1, 12'h018, c + 32'h0000_0001);
      tick(0, 1);
      repeat (2) @(posedge pclk);
      chk(saw_al, 1);
      chk(saw_wk, 1);
      chk(irq, 1);
      rdc(12'h004, 32'h0000_0003);
      rdc(12'h014, c + 32'h0000_0001);
      apb(1'b1, 12'h004, 32'h0000_0003);
      rdc(12'h004, 32'h0000_0000);
      chk(irq, 0);
      apb(1'b1, 12'h008, 32'h0000_0000);
      tick(0, 1);
      rdc(12'h004, 32'h0000_0002);
      chk(irq, 0);
      apb(1'b1, 12'h008, 32'h0000_0002);
      @(posedge pclk);
      chk(irq, 1);
      $display("alarm test done");
      // Backup contents survive the standby spell
      for (int i = 0; i < 10; i++) rdc(12'h040 + 12'(4 * i), {16'h0000, bk[i]});
      standby <= 1'b0;
      $display("retention test done");
      test_done();
   end
endmodule : tb_rtc_top

`default_nettype wire
